// *** sar_cfg.svh ***
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_STATUS_CTRL 8'h00
`define OFS_RESULT_HIGH 8'h04
`define OFS_RESULT_LOW 8'h08
`define OFS_CONV_CLOCK 8'h0c
`define OFS_PORT_DATA 8'h10
`define OFS_PORT_DIR 8'h14

// ----------------------------------------
// Status/control fields
// ----------------------------------------
`define SC_COMPLETE_BIT 7
`define SC_IRQ_EN_BIT 6
`define SC_CONT_BIT 5
`define SC_CHAN_MSB 4

// ----------------------------------------
// Clock register fields
// ----------------------------------------
`define CK_DIV_MSB 7
`define CK_DIV_LSB 5
`define CK_SRC_BIT 4
`define CK_FMT_HI_BIT 3
`define CK_FMT_LO_BIT 2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define STATUS_CTRL_RESET 8'h1f
`define CONV_CLOCK_RESET 8'h04
`define CHAN_OFF 5'h1f
`define CHAN_PINS 7
`define CONV_CYCLES 5'h10
`define RESULT_BITS 10

`endif

// *** sar_pkg.sv ***
package sar_pkg;

    typedef enum logic [1:0]
    {
        FMT_TRUNC = 2'b00,
        FMT_RIGHT = 2'b01,
        FMT_LEFT = 2'b10,
        FMT_LEFT_SIGNED = 2'b11
    } format_t;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_SYNC = 3'b010,
        ST_CONV = 3'b100
    } conv_state_t;

endpackage

// *** conv_prescaler.sv ***
`timescale 1ns/1ps
`include "sar_cfg.svh"

module conv_prescaler
    import sar_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic restart,
    input wire logic xtal_edge,
    input wire logic src_sel,
    input wire logic [2:0] div_sel,
    output logic tick
);

    // ----------------------------------------
    // Source select and power-of-two divide
    // ----------------------------------------
    logic [6:0] count_reg;
    logic [6:0] count_next;
    logic src_pulse;
    logic [6:0] div_mask;
    logic wrap;

    assign src_pulse = src_sel ? xtal_edge : 1'b1;
    assign div_mask = 7'((8'h01 << div_sel) - 8'h01);
    assign wrap = src_pulse && ((count_reg & div_mask) == div_mask);
    assign count_next = restart ? 7'h00 : (src_pulse ? 7'(count_reg + 7'h01) : count_reg);
    assign tick = wrap && !restart;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count_reg <= 7'h00;
        else if (ce)
            count_reg <= wrap ? 7'h00 : count_next;
    end

endmodule

// *** sar_engine.sv ***
`timescale 1ns/1ps
`include "sar_cfg.svh"

module sar_engine
    import sar_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic tick,
    input wire logic comp_in,
    output logic [9:0] trial,
    output logic [9:0] result,
    output logic done
);

    // ----------------------------------------
    // Bitwise successive approximation
    // ----------------------------------------
    logic [9:0] sar_reg;
    logic [9:0] bit_reg;
    logic [9:0] result_reg;
    logic done_reg;
    logic [9:0] kept;

    assign trial = sar_reg | bit_reg;
    assign kept = comp_in ? trial : sar_reg;
    assign result = result_reg;
    assign done = done_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sar_reg <= 10'h000;
            bit_reg <= 10'h200;
            result_reg <= 10'h000;
            done_reg <= 1'b0;
        end
        else if (ce)
        begin
            done_reg <= 1'b0;
            if (start)
            begin
                sar_reg <= 10'h000;
                bit_reg <= 10'h200;
            end
            else if (tick && bit_reg != 10'h000)
            begin
                sar_reg <= kept;
                bit_reg <= bit_reg >> 1;
                if (bit_reg == 10'h001)
                begin
                    result_reg <= kept;
                    done_reg <= 1'b1;
                end
            end
        end
    end

endmodule

// *** sar_adc_sequencer.sv ***
`timescale 1ns/1ps
`include "sar_cfg.svh"


module sar_adc_sequencer
    import sar_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic CRYSTAL_CLOCK,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic COMPARATOR,
    output logic [9:0] DAC_TRIAL,
    output logic [4:0] ANALOG_SELECT,
    output logic ANALOG_POWER,
    output logic CONV_IRQ,
    input wire logic [6:0] PORT_PIN_IN,
    output logic [6:0] PORT_PIN_OUT,
    output logic [6:0] PORT_PIN_OE_N,
    output logic [6:0] PIN_ANALOG
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic xtal_meta_reg;
    logic xtal_sync_reg;
    logic xtal_prev_reg;
    logic comp_meta_reg;
    logic comp_sync_reg;
    logic [6:0] pin_meta_reg;
    logic [6:0] pin_sync_reg;
    logic xtal_edge;

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            xtal_meta_reg <= 1'b0;
            xtal_sync_reg <= 1'b0;
            xtal_prev_reg <= 1'b0;
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
            pin_meta_reg <= 7'h00;
            pin_sync_reg <= 7'h00;
        end
        else if (CLK_EN)
        begin
            xtal_meta_reg <= CRYSTAL_CLOCK;
            xtal_sync_reg <= xtal_meta_reg;
            xtal_prev_reg <= xtal_sync_reg;
            comp_meta_reg <= COMPARATOR;
            comp_sync_reg <= comp_meta_reg;
            pin_meta_reg <= PORT_PIN_IN;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign xtal_edge = xtal_sync_reg && !xtal_prev_reg;

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic addr_phase;
    logic wr_sc;
    logic wr_clk;
    logic wr_pdata;
    logic wr_pdir;
    logic rd_high;
    logic rd_low;

    assign addr_phase = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign wr_sc = dp_valid_reg && dp_write_reg && dp_addr_reg == `OFS_STATUS_CTRL;
    assign wr_clk = dp_valid_reg && dp_write_reg && dp_addr_reg == `OFS_CONV_CLOCK;
    assign wr_pdata = dp_valid_reg && dp_write_reg && dp_addr_reg == `OFS_PORT_DATA;
    assign wr_pdir = dp_valid_reg && dp_write_reg && dp_addr_reg == `OFS_PORT_DIR;
    assign rd_high = addr_phase && !HWRITE && HADDR == `OFS_RESULT_HIGH;
    assign rd_low = addr_phase && !HWRITE && HADDR == `OFS_RESULT_LOW;

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
        end
        else if (CLK_EN && HREADY)
        begin
            dp_valid_reg <= HSEL && HTRANS[1];
            dp_write_reg <= HWRITE;
            dp_addr_reg <= HADDR;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic irq_en_reg;
    logic cont_reg;
    logic [4:0] chan_reg;
    logic [7:0] clk_reg;
    logic [6:0] pdata_reg;
    logic [6:0] pdir_reg;
    format_t fmt;
    logic conv_on;

    assign fmt = format_t'({clk_reg[`CK_FMT_HI_BIT], clk_reg[`CK_FMT_LO_BIT]});
    assign conv_on = chan_reg != `CHAN_OFF;

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            irq_en_reg <= 1'b0;
            cont_reg <= 1'b0;
            chan_reg <= `CHAN_OFF;
            clk_reg <= `CONV_CLOCK_RESET;
            pdata_reg <= 7'h00;
            pdir_reg <= 7'h00;
        end
        else if (CLK_EN)
        begin
            if (wr_sc)
            begin
                irq_en_reg <= HWDATA[`SC_IRQ_EN_BIT];
                cont_reg <= HWDATA[`SC_CONT_BIT];
                chan_reg <= HWDATA[`SC_CHAN_MSB:0];
            end
            if (wr_clk)
                clk_reg <= HWDATA[7:0];
            if (wr_pdata)
                pdata_reg <= HWDATA[6:0];
            if (wr_pdir)
                pdir_reg <= HWDATA[6:0];
        end
    end

    // ----------------------------------------
    // Pin ownership
    // ----------------------------------------
    logic [6:0] pin_taken;
    logic [6:0] pin_read;

    generate
        for (genvar i = 0; i < `CHAN_PINS; i++)
        begin : g_pin
            assign pin_taken[i] = chan_reg == 5'(i);
            assign PORT_PIN_OE_N[i] = pin_taken[i] || !pdir_reg[i];
            assign PORT_PIN_OUT[i] = pdata_reg[i] && !pin_taken[i];
            assign pin_read[i] = pin_taken[i] ? 1'b0 : (pdir_reg[i] ? pdata_reg[i] : pin_sync_reg[i]);
        end
    endgenerate

    assign PIN_ANALOG = pin_taken;
    assign ANALOG_SELECT = chan_reg;
    assign ANALOG_POWER = conv_on;

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    // The prescaler restarts on the start write, so the first tick lands a full
    // converter period later (up to one crystal edge less from the crystal source); that sync period is the 17th cycle.
    // The comparator passes two flip-flops, so from the bus clock a divide
    // below four leaves too little settling time per bit.
    conv_state_t state_reg;
    conv_state_t state_next;
    logic tick;
    logic eng_start;
    logic eng_done;
    logic [9:0] eng_result;
    logic [4:0] tick_cnt_reg;
    logic conv_end;
    logic result_ready_reg;

    assign eng_start = wr_sc;
    assign conv_end = state_reg == ST_CONV && tick && tick_cnt_reg == `CONV_CYCLES - 5'h01;

    conv_prescaler u_prescaler
    (
        .clk(CLOCK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .restart(wr_sc),
        .xtal_edge(xtal_edge),
        .src_sel(clk_reg[`CK_SRC_BIT]),
        .div_sel(clk_reg[`CK_DIV_MSB:`CK_DIV_LSB]),
        .tick(tick)
    );

    sar_engine u_engine
    (
        .clk(CLOCK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .start(eng_start || (state_reg == ST_SYNC)),
        .tick(tick && state_reg == ST_CONV),
        .comp_in(comp_sync_reg),
        .trial(DAC_TRIAL),
        .result(eng_result),
        .done(eng_done)
    );

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                state_next = ST_IDLE;
            ST_SYNC:
                if (tick)
                    state_next = ST_CONV;
            ST_CONV:
                if (conv_end)
                    state_next = cont_reg ? ST_SYNC : ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
        if (wr_sc)
            state_next = (HWDATA[`SC_CHAN_MSB:0] == `CHAN_OFF) ? ST_IDLE : ST_SYNC;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_reg <= ST_IDLE;
            tick_cnt_reg <= 5'h00;
            result_ready_reg <= 1'b0;
        end
        else if (CLK_EN)
        begin
            state_reg <= state_next;
            result_ready_reg <= (eng_done || result_ready_reg) && !eng_start && state_reg != ST_SYNC;
            if (state_reg != ST_CONV || wr_sc)
                tick_cnt_reg <= 5'h00;
            else if (tick)
                tick_cnt_reg <= 5'(tick_cnt_reg + 5'h01);
        end
    end

    // ----------------------------------------
    // Result formatting and interlock
    // ----------------------------------------
    logic [7:0] fmt_high;
    logic [7:0] fmt_low;
    logic [7:0] res_high_reg;
    logic [7:0] res_low_reg;
    logic lock_reg;
    logic complete_reg;
    logic first_done_reg;
    logic store;
    logic clear_flag;

    always_comb
    begin
        fmt_high = 8'h00;
        fmt_low = 8'h00;
        unique case (fmt)
            FMT_LEFT:
            begin
                fmt_high = eng_result[9:2];
                fmt_low = {eng_result[1:0], 6'h00};
            end
            FMT_LEFT_SIGNED:
            begin
                fmt_high = {~eng_result[9], eng_result[8:2]};
                fmt_low = {eng_result[1:0], 6'h00};
            end
            FMT_RIGHT:
            begin
                fmt_high = {6'h00, eng_result[9:8]};
                fmt_low = eng_result[7:0];
            end
            FMT_TRUNC:
            begin
                fmt_low = eng_result[9:2];
            end
        endcase
    end

    // Interlocked results are dropped, not queued: no buffer exists.
    // Results land only after the full sixteen ticks, not when the last bit settles
    assign store = conv_end && result_ready_reg && !lock_reg && !wr_sc;
    assign clear_flag = wr_sc || rd_high || rd_low;

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            res_high_reg <= 8'h00;
            res_low_reg <= 8'h00;
            lock_reg <= 1'b0;
            complete_reg <= 1'b0;
            first_done_reg <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (store)
            begin
                res_high_reg <= fmt_high;
                res_low_reg <= fmt_low;
            end
            if (rd_low || fmt == FMT_TRUNC)
                lock_reg <= 1'b0;
            else if (rd_high)
                lock_reg <= 1'b1;
            if (wr_sc)
                first_done_reg <= 1'b0;
            else if (store)
                first_done_reg <= 1'b1;
            // Set beats clear; in continuous mode only the first result sets it
            if (store && !(cont_reg && first_done_reg && !wr_sc))
                complete_reg <= 1'b1;
            else if (clear_flag)
                complete_reg <= 1'b0;
        end
    end

    assign CONV_IRQ = complete_reg && irq_en_reg;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [7:0] rd_byte;
    logic [31:0] rdata_reg;

    assign rd_byte =
        (HADDR == `OFS_STATUS_CTRL) ? {complete_reg, irq_en_reg, cont_reg, chan_reg} :
        (HADDR == `OFS_RESULT_HIGH) ? res_high_reg :
        (HADDR == `OFS_RESULT_LOW) ? res_low_reg :
        (HADDR == `OFS_CONV_CLOCK) ? clk_reg :
        (HADDR == `OFS_PORT_DATA) ? {1'b0, pin_read} :
        (HADDR == `OFS_PORT_DIR) ? {1'b0, pdir_reg} : 8'h00;

    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
            rdata_reg <= 32'h0000_0000;
        else if (CLK_EN && addr_phase && !HWRITE)
            rdata_reg <= {24'h000000, rd_byte};
    end

    assign HRDATA = rdata_reg;

endmodule

// *** analog_front.sv ***
`timescale 1ns/1ps

module analog_front
(
    input wire logic [9:0] trial,
    input wire logic [4:0] sel,
    input wire logic power,
    input wire logic [6:0][10:0] levels,
    output logic cmp
);
    logic [10:0] volts;

    // Unused codes read as ground here; real hardware gives an unknown result
    always_comb
    begin
        case (sel)
            5'h1d: volts = 11'h3ff;
            5'h1e: volts = 11'h000;
            default: volts = (sel < 5'd7) ? levels[sel[2:0]] : 11'h000;
        endcase
    end

    // Levels above full scale compare high against every trial code
    assign cmp = power & (volts >= {1'b0, trial});
endmodule

// *** sar_adc_sequencer_assertions.sv ***
`timescale 1ns/1ps

module sar_adc_sequencer_chk
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [4:0] ANALOG_SELECT,
    input wire logic ANALOG_POWER,
    input wire logic CONV_IRQ,
    input wire logic [6:0] PORT_PIN_OE_N,
    input wire logic [6:0] PIN_ANALOG
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    wire take = HSEL & HREADY & HTRANS[1];
    wire wr_ctrl = take & HWRITE & (HADDR == 8'h00);
    wire rd_data = take & !HWRITE & (HADDR == 8'h04 || HADDR == 8'h08);
    wire rd_port = take & !HWRITE & (HADDR == 8'h10);
    wire rd_hole = take & !HWRITE & (HADDR == 8'h40);
    logic wr_q;
    logic clr_q;
    logic [7:0] since_wr;

    // Saturating count of cycles since a control write took effect
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            wr_q <= 1'b0;
            clr_q <= 1'b0;
            since_wr <= 8'hff;
        end
        else
        begin
            wr_q <= wr_ctrl;
            clr_q <= wr_ctrl | rd_data;
            since_wr <= wr_q ? 8'h00 : since_wr + {7'h0, since_wr != 8'hff};
        end
    end

    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready or not okay");
    power_sel_a: assert property (ANALOG_POWER == (ANALOG_SELECT != 5'h1f))
        else $error("converter power does not follow channel code");
    pin_onehot_a: assert property
        (PIN_ANALOG == ((ANALOG_SELECT < 5'd7) ? 7'(7'h1 << ANALOG_SELECT) : 7'h0))
        else $error("pin ownership does not match channel");
    pin_input_a: assert property ((PIN_ANALOG & ~PORT_PIN_OE_N) == 7'h0)
        else $error("converter pin driven by port");
    conv_time_a: assert property ($rose(CONV_IRQ) |-> since_wr >= 8'd16)
        else $error("conversion finished too early");
    // A read clears in its address phase, a write one cycle later in its data phase
    irq_fall_a: assert property ($fell(CONV_IRQ) |-> clr_q || $past(clr_q))
        else $error("interrupt dropped without read or write");
    port_zero_a: assert property
        (rd_port |=> (HRDATA[6:0] & PIN_ANALOG & $past(PIN_ANALOG)) == 7'h0)
        else $error("taken pin reads nonzero");
    hole_read_a: assert property (rd_hole |=> HRDATA == 32'h0)
        else $error("unmapped read nonzero");

    cover property (wr_ctrl);
    cover property ($rose(CONV_IRQ));
    cover property (rd_port);
endmodule

bind sar_adc_sequencer sar_adc_sequencer_chk chk_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ANALOG_SELECT(ANALOG_SELECT),
    .ANALOG_POWER(ANALOG_POWER), .CONV_IRQ(CONV_IRQ), .PORT_PIN_OE_N(PORT_PIN_OE_N),
    .PIN_ANALOG(PIN_ANALOG));

// *** tb_sar_adc_sequencer.sv ***
`timescale 1ns/1ps
`include "sar_cfg.svh"

module tb_sar_adc_sequencer
    import sar_pkg::*;
;
    typedef struct packed {format_t f; logic [4:0] c; logic [10:0] v;
        logic [7:0] h; logic [7:0] l;} row_t;
    row_t rows [7] = '{
        '{FMT_RIGHT, 5'd3, 11'h2a5, 8'h02, 8'ha5}, '{FMT_LEFT, 5'd3, 11'h2a5, 8'ha9, 8'h40},
        '{FMT_LEFT_SIGNED, 5'd3, 11'h2a5, 8'h29, 8'h40},
        '{FMT_TRUNC, 5'd3, 11'h2a5, 8'h00, 8'ha9}, '{FMT_RIGHT, 5'd6, 11'h7ff, 8'h03, 8'hff},
        '{FMT_RIGHT, 5'h1d, 11'h000, 8'h03, 8'hff}, '{FMT_LEFT, 5'h1e, 11'h3ff, 8'h00, 8'h00}};
    logic clock = 0;
    logic sys_rst = 1;
    logic xtal = 0;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic hwrite = 0;
    logic [31:0] hwdata = 0;
    logic [6:0][10:0] levels = '0;
    logic [7:0] q;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    wire [31:0] hrdata;
    wire hreadyout, hresp, cmp, power, conv_irq;
    wire [9:0] trial;
    wire [4:0] sel;
    wire [6:0] pin_out, pin_oe_n, pin_analog;
    wire [6:0] pin_wire = (pin_out & ~pin_oe_n) | (7'h55 & pin_oe_n);

    always #12.5 clock = ~clock;
    always #55 xtal = ~xtal;

    sar_adc_sequencer dut_u (.CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(1'b1),
        .CRYSTAL_CLOCK(xtal), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .COMPARATOR(cmp), .DAC_TRIAL(trial),
        .ANALOG_SELECT(sel), .ANALOG_POWER(power), .CONV_IRQ(conv_irq),
        .PORT_PIN_IN(pin_wire), .PORT_PIN_OUT(pin_out), .PORT_PIN_OE_N(pin_oe_n),
        .PIN_ANALOG(pin_analog));
    analog_front far_u (.trial(trial), .sel(sel), .power(power), .levels(levels), .cmp(cmp));

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge clock);
        while (!hreadyout) @(posedge clock);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge clock);
        while (!hreadyout) @(posedge clock);
        q = hrdata[7:0];
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Samples on the falling edge so the design's updates have landed
    task automatic wait_irq;
        n = 0;
        while (conv_irq !== 1'b1 && n < 400)
        begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
    endtask

    task automatic timed(input logic [7:0] ck, input int lo, input int hi);
        bus(1, `OFS_CONV_CLOCK, ck);
        bus(1, `OFS_STATUS_CTRL, 8'h43);
        wait_irq;
        chk("conversion cycles", {7'h0, n >= lo && n <= hi}, 8'h01);
        bus(0, `OFS_RESULT_HIGH, 8'h00);
        bus(0, `OFS_RESULT_LOW, 8'h00);
    endtask

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under 5000 cycles
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fail_count++;
            finish_test;
        end
    end

    initial
    begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        foreach (rows[i])
        begin
            levels[rows[i].c[2:0]] <= rows[i].v;
            bus(1, `OFS_CONV_CLOCK, {3'b010, 1'b0, rows[i].f, 2'b00});
            bus(1, `OFS_STATUS_CTRL, {3'b010, rows[i].c});
            wait_irq;
            chk("done", {7'h0, conv_irq}, 8'h01);
            bus(0, `OFS_RESULT_HIGH, 8'h00);
            if (rows[i].f != FMT_TRUNC)
                chk("result high", q, rows[i].h);
            bus(0, `OFS_RESULT_LOW, 8'h00);
            chk("result low", q, rows[i].l);
            repeat (40) @(posedge clock);
            chk("single stop", {7'h0, conv_irq}, 8'h00);
        end
        timed(8'h34, 140, 162);
        timed(8'h44, 64, 76);
        // A second start mid-conversion must restart the full count
        bus(1, `OFS_STATUS_CTRL, 8'h43);
        repeat (30) @(posedge clock);
        bus(1, `OFS_STATUS_CTRL, 8'h43);
        wait_irq;
        chk("abort restart", {7'h0, n >= 64}, 8'h01);
        bus(0, `OFS_RESULT_HIGH, 8'h00);
        bus(0, `OFS_RESULT_LOW, 8'h00);
        bus(1, `OFS_CONV_CLOCK, 8'h44);
        levels[0] <= 11'h155;
        bus(1, `OFS_STATUS_CTRL, 8'h20);
        do bus(0, `OFS_STATUS_CTRL, 8'h00); while (q[7] !== 1'b1 && cyc < 29000);
        chk("first flag", q, 8'ha0);
        bus(0, `OFS_RESULT_HIGH, 8'h00);
        chk("locked high", q, 8'h01);
        levels[0] <= 11'h0aa;
        repeat (60) @(posedge clock);
        bus(0, `OFS_RESULT_LOW, 8'h00);
        chk("frozen low", q, 8'h55);
        repeat (150) @(posedge clock);
        bus(0, `OFS_RESULT_HIGH, 8'h00);
        chk("new high", q, 8'h00);
        bus(0, `OFS_RESULT_LOW, 8'h00);
        chk("new low", q, 8'haa);
        repeat (60) @(posedge clock);
        bus(0, `OFS_STATUS_CTRL, 8'h00);
        chk("flag stays clear", q, 8'h20);
        bus(1, `OFS_CONV_CLOCK, 8'h40);
        bus(1, `OFS_STATUS_CTRL, 8'h20);
        repeat (150) @(posedge clock);
        bus(0, `OFS_RESULT_HIGH, 8'h00);
        levels[0] <= 11'h004;
        repeat (150) @(posedge clock);
        bus(0, `OFS_RESULT_LOW, 8'h00);
        chk("no interlock", q, 8'h01);
        bus(1, `OFS_PORT_DIR, 8'h7f);
        bus(1, `OFS_PORT_DATA, 8'h7f);
        bus(1, `OFS_STATUS_CTRL, 8'h02);
        bus(1, `OFS_PORT_DIR, 8'h7f);
        @(negedge clock);
        chk("pin enables", {1'b0, pin_oe_n}, 8'h04);
        chk("pin owner", {1'b0, pin_analog}, 8'h04);
        @(posedge clock);
        bus(0, `OFS_PORT_DATA, 8'h00);
        chk("port read", q, 8'h7b);
        bus(0, 8'h40, 8'h00);
        chk("unmapped read", q, 8'h00);
        sys_rst <= 1'b1;
        repeat (8) @(posedge clock);
        chk("reset select", {3'h0, sel}, 8'h1f);
        chk("reset power", {7'h0, power}, 8'h00);
        chk("reset trial", trial[9:2], 8'h80);
        sys_rst <= 1'b0;
        @(posedge clock);
        bus(0, `OFS_STATUS_CTRL, 8'h00);
        chk("status reset", q, 8'h1f);
        bus(0, `OFS_CONV_CLOCK, 8'h00);
        chk("clock reset", q, 8'h04);
        finish_test;
    end
endmodule
